/* dip_map.svh */
// Offsets, field positions, reset values and weights of the interpolation datapath.
// Assumes inclusion by bare name; definitions only.
`ifndef DIP_MAP_SVH
`define DIP_MAP_SVH
`define DIP_ADDR_RATIO 12'h110
`define DIP_ADDR_PATH 12'h111
`define DIP_BIT_NRZ 0
`define DIP_BIT_DUALMOD 2
`define DIP_BIT_WIDE 4
`define DIP_BIT_NCO 6
`define DIP_RATIO_RST 8'h00
`define DIP_PATH_RST 8'h00
`define DIP_CTL_RATIO 8'h00
`define DIP_CTL_PATH 8'h04
`define DIP_CTL_SAMPLE 8'h08
`define DIP_CTL_BACKOFF 8'h0c
`define DIP_CTL_STATUS 8'h10
`define DIP_BACKOFF_RST 16'h0001
`define DIP_ADDONE_RST 1'b1
`define DIP_W_THIRD 17'h05555
`define DIP_W_HALF 17'h08000
`define DIP_W_TWOTHIRD 17'h0aaab
`define DIP_W_FULL 17'h10000
`endif

/* dip_pkg.sv */
// Types shared by both ends of the interpolation datapath.
// Assumes nothing beyond the compile order.
package dip_pkg;
  typedef logic signed [15:0] dip_sample_t;
  typedef logic signed [16:0] dip_level_t;
  typedef enum logic [2:0] {
    DIP_MOD_NONE = 3'b001,
    DIP_MOD_INT = 3'b010,
    DIP_MOD_DUAL = 3'b100
  } dip_mod_e;
endpackage

/* dip_link_if.sv */
// Link between the sample source and the datapath: register port and sample stream.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
interface dip_link_if;
  logic reg_wr;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic smp_valid;
  logic smp_ready;
  dip_pkg::dip_sample_t smp_i;
  dip_pkg::dip_sample_t smp_q;
  modport dev (input reg_wr, reg_addr, reg_wdata, smp_valid, smp_i, smp_q, output reg_rdata, smp_ready);
  modport src (output reg_wr, reg_addr, reg_wdata, smp_valid, smp_i, smp_q, input reg_rdata, smp_ready);
endinterface

/* dip_interp_stage.sv */
// One interpolation stage: 1x pass, 2x or 3x, linear or hold between samples.
// Assumes the consumer may stall it; one idle cycle per input sample.
`timescale 1ns/1ps
`include "dip_map.svh"
module dip_interp_stage #(
  parameter int W = 16
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic enable, // Interpolate when high
  input wire logic factor3, // 3x instead of 2x
  input wire logic hold_mode, // Repeat sample instead of linear step
  input wire logic in_valid, // Input offered
  output logic in_ready, // Input taken
  input wire logic signed [W-1:0] in_i, // Input I
  input wire logic signed [W-1:0] in_q, // Input Q
  output logic out_valid, // Output offered
  input wire logic out_ready, // Output taken
  output logic signed [W-1:0] out_i, // Output I
  output logic signed [W-1:0] out_q // Output Q
);
  // Elaboration guard: the weight product is sized for 4 to 32 bit samples
  if (W < 4 || W > 32) begin : g_bad_w
    $error("dip_interp_stage: W out of range");
  end

  logic signed [W-1:0] prev_i, prev_q, cur_i, cur_q;
  logic busy;
  logic [1:0] cnt, last;
  logic [1:0] next_last;

  // Step from a towards b by phase k of last+1; final phase lands on b
  function automatic logic signed [W-1:0] interp(input logic signed [W-1:0] a, input logic signed [W-1:0] b,
      input logic [1:0] k, input logic [1:0] lst, input logic hold);
    logic signed [W:0] d;
    logic [16:0] wgt;
    logic signed [W+18:0] p;
    logic signed [W:0] s;
    d = {b[W-1], b} - {a[W-1], a};
    if (hold || k == lst) wgt = `DIP_W_FULL;
    else if (lst == 2'd2) wgt = (k == 2'd0) ? `DIP_W_THIRD : `DIP_W_TWOTHIRD;
    else wgt = `DIP_W_HALF;
    p = d * $signed({1'b0, wgt});
    s = {a[W-1], a} + p[W+16:16];
    interp = s[W-1:0];
  endfunction

  always_comb begin
    next_last = enable ? (factor3 ? 2'd2 : 2'd1) : 2'd0;
  end

  // Ready only between samples; keeps the phase sequence atomic
  assign in_ready = !busy;
  assign out_valid = busy;

  // Phase sequencing and registered output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      cnt <= 2'd0;
      last <= 2'd0;
      prev_i <= '0;
      prev_q <= '0;
      cur_i <= '0;
      cur_q <= '0;
      out_i <= '0;
      out_q <= '0;
    end else if (!busy && in_valid) begin
      busy <= 1'b1;
      cnt <= 2'd0;
      last <= next_last; // Phase count latched per sample, not mid-sequence; hold_mode is read live
      prev_i <= cur_i;
      prev_q <= cur_q;
      cur_i <= in_i;
      cur_q <= in_q;
      out_i <= interp(cur_i, in_i, 2'd0, next_last, hold_mode);
      out_q <= interp(cur_q, in_q, 2'd0, next_last, hold_mode);
    end else if (busy && out_ready) begin
      if (cnt == last) begin
        busy <= 1'b0;
      end else begin
        cnt <= cnt + 2'd1;
        out_i <= interp(prev_i, cur_i, cnt + 2'd1, last, hold_mode);
        out_q <= interp(prev_q, cur_q, cnt + 2'd1, last, hold_mode);
      end
    end
  end
endmodule

/* dip_datapath_dev.sv */
// Interpolation datapath end: config registers, stage cascade, modulator,
// optional NRZ doubling and converter decoder.
// Assumes the converter takes one output transfer on every pclk edge.
`timescale 1ns/1ps
`include "dip_map.svh"
module dip_datapath_dev #(
  parameter int ACC_W = 48
) (
  input wire logic pclk, // Converter clock
  input wire logic presetn, // Async reset, active low
  dip_link_if.dev link, // Register port and sample stream
  input wire logic [ACC_W-1:0] frequency_word, // NCO step per output sample
  input wire logic [ACC_W-1:0] modulus_a, // Fraction numerator
  input wire logic [ACC_W-1:0] modulus_b, // Fraction denominator
  output dip_pkg::dip_level_t dac_level0, // First converter level
  output dip_pkg::dip_level_t dac_level1, // Second level when paired
  output logic dac_valid, // Levels valid this cycle
  output logic dac_pair, // Both levels used (NRZ)
  output dip_pkg::dip_mod_e mod_mode // Active modulation
);
  import dip_pkg::*;

  // Elaboration guard: the quadrant rotation needs the top two phase bits
  if (ACC_W < 8 || ACC_W > 64) begin : g_bad_acc
    $error("dip_datapath_dev: ACC_W out of range");
  end

  logic [7:0] upsample_ratio_reg;
  logic [7:0] path_config;
  logic wide_band_select, nrz_en, bypass, first_3x;
  logic [3:0] stage_en;
  logic ch_valid [0:4];
  logic ch_ready [0:4];
  dip_sample_t ch_i [0:4];
  dip_sample_t ch_q [0:4];
  logic [ACC_W-1:0] phase, frac;
  logic [ACC_W:0] frac_sum;
  logic carry;
  dip_mod_e next_mod_mode;
  dip_sample_t rot;
  dip_sample_t mod_real, nrz_prev;
  logic mod_valid;

  // Saturating negate keeps -32768 from wrapping
  function automatic dip_sample_t neg(input dip_sample_t x);
    neg = (x == 16'sh8000) ? 16'sh7fff : -x;
  endfunction

  // Zero and positive codes sit one level up; negatives unchanged
  function automatic dip_level_t decode(input dip_sample_t x);
    decode = x[15] ? {1'b1, x} : dip_level_t'({1'b0, x} + 17'h00001);
  endfunction

  // Config registers on the link register port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upsample_ratio_reg <= `DIP_RATIO_RST;
      path_config <= `DIP_PATH_RST;
    end else if (link.reg_wr) begin
      if (link.reg_addr == `DIP_ADDR_RATIO) begin
        upsample_ratio_reg <= link.reg_wdata;
      end else if (link.reg_addr == `DIP_ADDR_PATH) begin
        path_config <= link.reg_wdata;
      end
    end
  end

  // Readback follows the addressed register one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.reg_rdata <= 8'h00;
    end else if (link.reg_addr == `DIP_ADDR_RATIO) begin
      link.reg_rdata <= upsample_ratio_reg;
    end else if (link.reg_addr == `DIP_ADDR_PATH) begin
      link.reg_rdata <= path_config;
    end else begin
      link.reg_rdata <= 8'h00;
    end
  end

  assign wide_band_select = path_config[`DIP_BIT_WIDE];
  assign nrz_en = path_config[`DIP_BIT_NRZ];

  // Ratio decode: first stage 2x/3x then up to three 2x stages
  always_comb begin
    bypass = 1'b0;
    first_3x = 1'b0;
    stage_en = 4'b0000;
    case (upsample_ratio_reg[3:0])
      4'h1: stage_en = 4'b0001;
      4'h2: begin
        stage_en = 4'b0001;
        first_3x = 1'b1;
      end
      4'h3: stage_en = 4'b0011;
      4'h4: begin
        stage_en = 4'b0011;
        first_3x = 1'b1;
      end
      4'h5: stage_en = 4'b0111;
      4'h6: begin
        stage_en = 4'b0111;
        first_3x = 1'b1;
      end
      4'h7: stage_en = 4'b1111;
      4'h8: begin
        stage_en = 4'b1111;
        first_3x = 1'b1;
      end
      default: bypass = 1'b1; // Reserved codes fall back to 1x
    endcase
  end

  // Bypass stream is real: Q is dropped, so NCO use here yields images
  assign ch_valid[0] = link.smp_valid;
  assign link.smp_ready = ch_ready[0];
  assign ch_i[0] = link.smp_i;
  assign ch_q[0] = bypass ? 16'sh0000 : link.smp_q;

  // Cascade: stage 0 is the 2x/3x entry, stages 1..3 the halving 2x stages
  // Limitation: linear and hold steps only approximate the in-band flatness and
  // image rejection of true half-band filters
  for (genvar k = 0; k < 4; k++) begin : g_stage
    dip_interp_stage #(.W(16)) u_stage (
      .pclk(pclk),
      .presetn(presetn),
      .enable(stage_en[k]),
      .factor3((k == 0) && first_3x),
      .hold_mode((k == 0) && wide_band_select),
      .in_valid(ch_valid[k]),
      .in_ready(ch_ready[k]),
      .in_i(ch_i[k]),
      .in_q(ch_q[k]),
      .out_valid(ch_valid[k+1]),
      .out_ready(ch_ready[k+1]),
      .out_i(ch_i[k+1]),
      .out_q(ch_q[k+1])
    );
  end

  // Converter never stalls the chain end
  assign ch_ready[4] = 1'b1;

  // Modulation select from bits 6 and 2
  always_comb begin
    if (!path_config[`DIP_BIT_NCO]) begin
      next_mod_mode = DIP_MOD_NONE;
    end else if (path_config[`DIP_BIT_DUALMOD]) begin
      next_mod_mode = DIP_MOD_DUAL;
    end else begin
      next_mod_mode = DIP_MOD_INT;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_mode <= DIP_MOD_NONE;
    end else begin
      mod_mode <= next_mod_mode;
    end
  end

  // Fraction A/B adds one extra LSB to the step when it wraps
  assign frac_sum = {1'b0, frac} + {1'b0, modulus_a};
  assign carry = (mod_mode == DIP_MOD_DUAL) && (modulus_b != '0) && (frac_sum >= {1'b0, modulus_b});

  // Phase accumulator advances once per sample leaving the cascade
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= '0;
      frac <= '0;
    end else if (ch_valid[4] && mod_mode != DIP_MOD_NONE) begin
      phase <= phase + frequency_word + {{(ACC_W-1){1'b0}}, carry};
      if (mod_mode == DIP_MOD_DUAL && modulus_b != '0) begin
        frac <= carry ? ACC_W'(frac_sum - {1'b0, modulus_b}) : frac_sum[ACC_W-1:0];
      end
    end
  end

  // Quadrant rotation: real part of I/Q times the carrier's quarter phase
  always_comb begin
    case (phase[ACC_W-1:ACC_W-2])
      2'd0: rot = ch_i[4];
      2'd1: rot = neg(ch_q[4]);
      2'd2: rot = neg(ch_i[4]);
      default: rot = ch_q[4];
    endcase
  end

  // Modulator sits after the cascade and before the NRZ stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_valid <= 1'b0;
      mod_real <= 16'sh0000;
    end else begin
      mod_valid <= ch_valid[4];
      if (ch_valid[4]) begin
        mod_real <= (mod_mode == DIP_MOD_NONE) ? ch_i[4] : rot;
      end
    end
  end

  // NRZ doubling: two levels per clock, midpoint then sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nrz_prev <= 16'sh0000;
      dac_level0 <= 17'sh00001;
      dac_level1 <= 17'sh00001;
      dac_valid <= 1'b0;
      dac_pair <= 1'b0;
    end else begin
      dac_valid <= mod_valid;
      dac_pair <= nrz_en;
      if (mod_valid) begin
        nrz_prev <= mod_real;
        dac_level0 <= decode(nrz_en ? dip_sample_t'(({nrz_prev[15], nrz_prev} + {mod_real[15], mod_real}) >>> 1)
                                    : mod_real);
        dac_level1 <= decode(nrz_en ? mod_real : 16'sh0000);
      end
    end
  end
endmodule

/* dip_source_ctrl.sv */
// Sample source end: APB slave that programs the datapath and pushes
// conditioned samples over the link.
// Assumes an APB master on pclk and the datapath end on the same link.
`timescale 1ns/1ps
`include "dip_map.svh"
module dip_source_ctrl (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  dip_link_if.src link // Register port and sample stream
);
  import dip_pkg::*;

  logic [15:0] backoff;
  logic add_one;
  logic mapped, acc, wr_ok;
  logic [15:0] eff, lim;

  // Clamp to the backed-off range, then lift by one
  function automatic dip_sample_t cond(input dip_sample_t x, input logic [15:0] l, input logic a1);
    dip_sample_t c;
    c = (x > $signed(l)) ? $signed(l) : (x < -$signed(l)) ? -$signed(l) : x;
    cond = a1 ? c + 16'sh0001 : c;
  endfunction

  assign mapped = (paddr == `DIP_CTL_RATIO) || (paddr == `DIP_CTL_PATH) || (paddr == `DIP_CTL_SAMPLE) ||
                  (paddr == `DIP_CTL_BACKOFF) || (paddr == `DIP_CTL_STATUS);
  assign acc = psel && penable;
  // A sample write waits while the previous sample is still on the link
  assign pready = !(pwrite && paddr == `DIP_CTL_SAMPLE && link.smp_valid);
  assign pslverr = acc && !mapped;
  assign wr_ok = acc && pready && pwrite && mapped;
  assign eff = (backoff == 16'h0000 && add_one) ? 16'h0001 : backoff;
  assign lim = 16'h7fff - eff;

  // Backoff and lift settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      backoff <= `DIP_BACKOFF_RST;
      add_one <= `DIP_ADDONE_RST;
    end else if (wr_ok && paddr == `DIP_CTL_BACKOFF) begin
      backoff <= pwdata[15:0];
      add_one <= pwdata[16];
    end
  end

  // Config writes forwarded as one-cycle register-port writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.reg_wr <= 1'b0;
      link.reg_addr <= `DIP_ADDR_RATIO;
      link.reg_wdata <= 8'h00;
    end else begin
      link.reg_wr <= wr_ok && (paddr == `DIP_CTL_RATIO || paddr == `DIP_CTL_PATH);
      if (wr_ok && paddr == `DIP_CTL_RATIO) begin
        link.reg_addr <= `DIP_ADDR_RATIO;
        link.reg_wdata <= pwdata[7:0];
      end else if (wr_ok && paddr == `DIP_CTL_PATH) begin
        link.reg_addr <= `DIP_ADDR_PATH;
        link.reg_wdata <= pwdata[7:0];
      end
    end
  end

  // Pending sample held until the datapath takes it; rate set by its ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.smp_valid <= 1'b0;
      link.smp_i <= 16'sh0000;
      link.smp_q <= 16'sh0000;
    end else if (wr_ok && paddr == `DIP_CTL_SAMPLE) begin
      link.smp_valid <= 1'b1;
      link.smp_i <= cond(pwdata[15:0], lim, add_one);
      link.smp_q <= cond(pwdata[31:16], lim, add_one);
    end else if (link.smp_ready) begin
      link.smp_valid <= 1'b0;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      if (paddr == `DIP_CTL_BACKOFF) begin
        prdata <= {15'h0000, add_one, backoff};
      end else if (paddr == `DIP_CTL_STATUS) begin
        prdata <= {15'h0000, link.reg_addr == `DIP_ADDR_PATH, link.reg_rdata, 7'h00, link.smp_valid};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end
endmodule

/* dip_link_checker.sv */
// Concurrent checks on the link between the source end and the datapath end.
// Assumes instantiation beside the link interface; one clock domain.
`timescale 1ns/1ps
module dip_link_checker (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic reg_wr, // Register write pulse
  input wire logic [11:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic [7:0] reg_rdata, // Register read back
  input wire logic smp_valid, // Sample offered
  input wire logic smp_ready, // Sample taken
  input wire dip_pkg::dip_sample_t smp_i, // Sample I
  input wire dip_pkg::dip_sample_t smp_q // Sample Q
);
  import dip_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Only the two datapath registers may ever be addressed
  chk_addr_known: assert property (reg_addr inside {12'h110, 12'h111})
    else $error("link register address outside the datapath map");
  // Address moves only together with a write
  chk_addr_moves: assert property ($changed(reg_addr) |-> reg_wr)
    else $error("link address changed without a write");
  chk_wr_single: assert property (reg_wr |=> !reg_wr)
    else $error("register write pulse longer than one cycle");
  // Read back shows the written byte two edges later
  chk_rdata_back: assert property (reg_wr ##1 (!reg_wr && $stable(reg_addr)) |=>
    reg_rdata == $past(reg_wdata, 2))
    else $error("register read back differs from written value");
  // An offered sample stands unchanged until taken
  chk_smp_stands: assert property (smp_valid && !smp_ready |=>
    smp_valid && $stable(smp_i) && $stable(smp_q))
    else $error("sample changed or withdrawn before it was taken");
  // Stage zero is busy at least one cycle after a take
  chk_take_gap: assert property (smp_valid && smp_ready |=> !smp_ready)
    else $error("two samples taken on adjacent edges");
  // Backed-off samples never reach the most negative code
  chk_smp_backoff: assert property (smp_valid |-> smp_i != 16'sh8000 && smp_q != 16'sh8000)
    else $error("sample at full negative scale despite backoff");
  chk_take_bound: assert property (smp_valid |-> ##[0:300] smp_ready)
    else $error("offered sample not taken in time");
  cov_take: cover property (smp_valid && smp_ready);
  cov_stall: cover property (smp_valid && !smp_ready);
  cov_path_wr: cover property (reg_wr && reg_addr == 12'h111);
endmodule

/* dac_interp_datapath_config_test.sv */
// Self-checking bench: APB master on the source end, linked to the datapath end.
// Assumes a 10 MHz pclk shared by both ends.
`timescale 1ns/1ps
module dac_interp_datapath_config_test;
  import dip_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dip_level_t lv0;
  dip_level_t lv1;
  logic dvalid;
  logic dpair;
  dip_mod_e mmode;
  logic [31:0] rd;
  logic er;
  int error_cnt = 0;
  int checked = 0;
  dip_link_if link ();
  dip_source_ctrl i_dip_source_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link));
  // NCO words are fixed; modes are selected and the integer NCO is run in bypass
  dip_datapath_dev i_dip_datapath_dev (.pclk(pclk), .presetn(presetn), .link(link),
    .frequency_word(48'h1000_0000_0000), .modulus_a(48'h3), .modulus_b(48'h5), .dac_level0(lv0),
    .dac_level1(lv1), .dac_valid(dvalid), .dac_pair(dpair), .mod_mode(mmode));
  dip_link_checker i_dip_link_checker (.pclk(pclk), .presetn(presetn), .reg_wr(link.reg_wr),
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
    .smp_valid(link.smp_valid), .smp_ready(link.smp_ready), .smp_i(link.smp_i), .smp_q(link.smp_q));
  always #50 pclk = ~pclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer: setup, then access held until pready is seen high at a rising edge
  // Read data and error are taken at that same edge; only the watchdog ends a long wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic get_out(output dip_level_t a, output dip_level_t b, output logic p);
    int n;
    n = 0;
    @(negedge pclk);
    while (dvalid !== 1'b1 && n < 300) begin
      @(negedge pclk);
      n++;
    end
    a = lv0;
    b = lv1;
    p = dpair;
    check(dvalid, 1'b1);
  endtask
  task automatic count_out(input int cyc, output int c, output logic p);
    c = 0;
    p = 1'b0;
    repeat (cyc) begin
      @(negedge pclk);
      if (dvalid === 1'b1) begin
        c++;
        p = dpair;
      end
    end
  endtask
  // Source conditioning followed by the zero-free decoder
  function automatic dip_level_t exp_lvl(input int s, input int b, input bit a);
    int e;
    int v;
    e = (b == 0 && a) ? 1 : b;
    v = (s > 32767 - e) ? 32767 - e : (s < e - 32767) ? e - 32767 : s;
    v = v + int'(a);
    return dip_level_t'((v >= 0) ? v + 1 : v);
  endfunction
  task automatic t_reset();
    check(mmode, DIP_MOD_NONE);
    check(lv0, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h0001_0001);
    apb(1'b0, 8'h20, 32'h0);
    check(er, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    check(rd[16:8], 9'h000);
  endtask
  task automatic t_modes();
    logic [7:0] pv [4] = '{8'h00, 8'h40, 8'h44, 8'h04};
    dip_mod_e me [4] = '{DIP_MOD_NONE, DIP_MOD_INT, DIP_MOD_DUAL, DIP_MOD_NONE};
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 8'h04, {24'h0, pv[k]});
      repeat (3) @(posedge pclk);
      apb(1'b0, 8'h10, 32'h0);
      check(rd[16:8], {1'b1, pv[k]});
      check(mmode, me[k]);
    end
  endtask
  // Bypass: one level per sample, decoder shifts zero and positives up
  task automatic t_decode();
    int tv [7][3] = '{'{1, 1, 0}, '{1, 1, -5}, '{1, 1, 32767}, '{1, 1, -32768}, '{0, 0, 0}, '{0, 0, -1},
      '{3, 0, 32767}};
    dip_level_t a;
    dip_level_t b;
    logic p;
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h0);
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, 8'h0c, {15'h0, tv[k][1][0], 16'(tv[k][0])});
      apb(1'b1, 8'h08, {16'h0, 16'(tv[k][2])});
      get_out(a, b, p);
      check(a, exp_lvl(tv[k][2], tv[k][0], tv[k][1][0]));
      check(b, 32'h1);
      check(p, 1'b0);
    end
  endtask
  task automatic t_ratio();
    int rt [9] = '{1, 2, 3, 4, 6, 8, 12, 16, 24};
    int c;
    logic p;
    for (int k = 0; k < 9; k++) begin
      apb(1'b1, 8'h00, k);
      apb(1'b1, 8'h08, 32'h0000_0100);
      count_out(250, c, p);
      check(c, rt[k]);
    end
  endtask
  // Wide band repeats the sample, so both 2x phases match
  task automatic t_hold();
    dip_level_t a;
    dip_level_t b;
    logic p;
    apb(1'b1, 8'h04, 32'h10);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b1, 8'h08, 32'd1000);
    get_out(a, b, p);
    check(a, 32'd1001);
    get_out(a, b, p);
    check(a, 32'd1001);
  endtask
  // Second sample is offered while stage zero is still busy
  task automatic t_nrz();
    dip_level_t a;
    dip_level_t b;
    logic p;
    int c;
    apb(1'b1, 8'h04, 32'h01);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h08, 32'd100);
    get_out(a, b, p);
    check(b, 32'd101);
    check(a, 32'd551);
    check(p, 1'b1);
    apb(1'b1, 8'h00, 32'h8);
    apb(1'b1, 8'h08, 32'd7);
    apb(1'b1, 8'h08, 32'd9);
    count_out(400, c, p);
    check(c, 48);
    check(p, 1'b1);
  endtask
  // Integer NCO in bypass: after four samples the carrier has turned a quarter,
  // so only the dropped Q part reaches the converter (image case)
  task automatic t_nco();
    dip_level_t a;
    dip_level_t b;
    logic p;
    apb(1'b1, 8'h04, 32'h40);
    apb(1'b1, 8'h00, 32'h0);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, 8'h08, 32'd200);
      get_out(a, b, p);
      check(a, (k < 4) ? 32'd201 : 32'd1);
    end
  endtask
  task automatic end_of_test();
    $display("Mismatches %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_decode();
    t_ratio();
    t_hold();
    t_nrz();
    t_nco();
    end_of_test();
  end
  // Whole run needs about 3000 cycles; a hang is cut off well past that
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    end_of_test();
  end
endmodule
